// file: common/irq_flags_pkg.sv
// Constants for the peripheral interrupt flag block: register map,
// field positions and reset values.
// Assumes a 32-bit APB slave with byte addresses four times the index.
package irq_flags_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_FLAGS_ONE   = 8'h0C;
   localparam logic [7:0] IDX_FLAGS_TWO   = 8'h0D;
   localparam logic [7:0] IDX_ENABLES_ONE = 8'h8C;
   localparam logic [7:0] IDX_ENABLES_TWO = 8'h8D;
   localparam logic [7:0] IDX_CORE_CTRL   = 8'h8B;
   localparam logic [7:0] IDX_RX_DATA     = 8'h1A;
   localparam logic [7:0] IDX_TX_DATA     = 8'h19;
   // Flag and enable bit positions, first register
   localparam int BIT_PARALLEL  = 7;
   localparam int BIT_CONVERTER = 6;
   localparam int BIT_RECEIVE   = 5;
   localparam int BIT_TRANSMIT  = 4;
   localparam int BIT_SYNC      = 3;
   localparam int BIT_CAPCMP1   = 2;
   localparam int BIT_PERIOD    = 1;
   localparam int BIT_OVERFLOW  = 0;
   // Second register: capture/compare unit two
   localparam int BIT_CAPCMP2   = 0;
   // Core control bits
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PERIPH_EN = 6;
   // Read-only buffer flags in the first flag register
   localparam logic [7:0] MASK_FLAGS_RO = 8'h30;
   // Reset values
   localparam logic [7:0] RST_FLAGS    = 8'h00;
   localparam logic [7:0] RST_ENABLES  = 8'h00;
   localparam logic [7:0] RST_CORE     = 8'h00;
   localparam logic [7:0] RST_DATA     = 8'h00;
endpackage

// file: core/event_flag.sv
// One sticky interrupt flag: hardware set, software write-zero clear.
// Assumes set and clear are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module event_flag
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic set_pulse,   // Event from the peripheral
   input  wire logic clr_pulse,   // Software writes zero
   input  wire logic wr_one,      // Software writes one
   output logic      flag_ff
);
   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flag_ff <= 1'b0;
      else if (set_pulse || wr_one)
         flag_ff <= 1'b1;
      else if (clr_pulse)
         flag_ff <= 1'b0;
   end

   // Flag held unless cleared
   AST_STICKY: assert property (@(posedge clk) disable iff (!arst_n)
      flag_ff && !clr_pulse |=> flag_ff)
      else $error("flag dropped without clear");
   AST_SET: assert property (@(posedge clk) disable iff (!arst_n)
      set_pulse |=> flag_ff)
      else $error("event lost");
endmodule
`default_nettype wire

// file: core/periph_irq.sv
// Peripheral interrupt flags, enables and core gating behind APB.
// Assumes event inputs come from logic on clk as one-cycle pulses and
// the buffer level inputs are steady levels on the same clock.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module periph_irq
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Peripheral events
   input  wire logic        parallel_access,
   input  wire logic        conversion_done,
   input  wire logic        rx_buffer_full,
   input  wire logic        tx_buffer_empty,
   input  wire logic        sync_serial_done,
   input  wire logic        capcmp_one_pwm_mode,
   input  wire logic        capcmp_one_event,
   input  wire logic        period_match,
   input  wire logic        timer_one_overflow,
   input  wire logic        capcmp_two_event,
   // Side effects toward the serial unit
   output logic             rx_data_read_ff,
   output logic             tx_data_write_ff,
   output logic [7:0]       tx_data_ff,
   // Request to the core
   output logic             periph_irq_ff
);
   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic        wr_en;            // Write access phase
   logic        rd_en;            // Read access phase
   logic [7:0]  idx;              // Word index of the access
   logic        flags_one_wr;     // Write to flags one
   logic        flags_two_wr;     // Write to flags two
   logic [7:0]  wbyte;            // Low byte of write data

   // Word index from byte address; low bits ignored
   function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
      hit = (a == i);
   endfunction

   assign wr_en        = psel && penable && pwrite;
   assign rd_en        = psel && penable && !pwrite;
   assign idx          = paddr[9:2];
   assign wbyte        = pwdata[7:0];
   assign flags_one_wr = wr_en && hit(idx, irq_flags_pkg::IDX_FLAGS_ONE);
   assign flags_two_wr = wr_en && hit(idx, irq_flags_pkg::IDX_FLAGS_TWO);

   // ---------------------------------------------------------------
   // Enable and control registers
   // ---------------------------------------------------------------
   logic [7:0] enables_one_ff;    // Per-source enables, first bank
   logic [7:0] enables_two_ff;    // Unit two enable in bit 0
   logic [7:0] core_ctrl_ff;      // Global and peripheral enables

   // Software-owned enables; enables one kept as written, reserved bits of
   // enables two and core control are forced to zero on write
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         enables_one_ff <= irq_flags_pkg::RST_ENABLES;
         enables_two_ff <= irq_flags_pkg::RST_ENABLES;
         core_ctrl_ff   <= irq_flags_pkg::RST_CORE;
      end
      else
      begin
         if (wr_en && hit(idx, irq_flags_pkg::IDX_ENABLES_ONE))
            enables_one_ff <= wbyte;
         if (wr_en && hit(idx, irq_flags_pkg::IDX_ENABLES_TWO))
            enables_two_ff <= {7'h00, wbyte[irq_flags_pkg::BIT_CAPCMP2]};
         if (wr_en && hit(idx, irq_flags_pkg::IDX_CORE_CTRL))
            core_ctrl_ff <= {wbyte[7:6], 6'h00};
      end
   end

   // ---------------------------------------------------------------
   // Sticky flags
   // ---------------------------------------------------------------
   logic [7:0] set_one;           // Hardware set per bit
   logic [7:0] flags_one;         // Assembled flag byte
   logic       flag_two;          // Unit two flag
   logic       capcmp_one_set;    // Unit one event outside PWM

   // PWM mode leaves the unit one flag alone
   assign capcmp_one_set = capcmp_one_event && !capcmp_one_pwm_mode;

   // Event vector by bit position; buffer bits are not latched
   always_comb
   begin
      set_one = 8'h00;
      set_one[irq_flags_pkg::BIT_PARALLEL]  = parallel_access;
      set_one[irq_flags_pkg::BIT_CONVERTER] = conversion_done;
      set_one[irq_flags_pkg::BIT_SYNC]      = sync_serial_done;
      set_one[irq_flags_pkg::BIT_CAPCMP1]   = capcmp_one_set;
      set_one[irq_flags_pkg::BIT_PERIOD]    = period_match;
      set_one[irq_flags_pkg::BIT_OVERFLOW]  = timer_one_overflow;
   end

   // Sticky flags set without regard to enables; only a zero write clears
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_flag
         if (g == irq_flags_pkg::BIT_RECEIVE || g == irq_flags_pkg::BIT_TRANSMIT)
         begin : g_level
            // Buffer state bits are driven live below
         end
         else
         begin : g_sticky
            event_flag u_flag
            (
               .clk       (clk),
               .arst_n    (arst_n),
               .set_pulse (set_one[g]),
               .clr_pulse (flags_one_wr && !wbyte[g]),
               .wr_one    (flags_one_wr && wbyte[g]),
               .flag_ff   (flags_one[g])
            );
         end
      end
   endgenerate

   // Read-only buffer state; cleared by data register access upstream
   assign flags_one[irq_flags_pkg::BIT_RECEIVE]  = rx_buffer_full;
   assign flags_one[irq_flags_pkg::BIT_TRANSMIT] = tx_buffer_empty;

   event_flag u_flag_two
   (
      .clk       (clk),
      .arst_n    (arst_n),
      .set_pulse (capcmp_two_event),
      .clr_pulse (flags_two_wr && !wbyte[irq_flags_pkg::BIT_CAPCMP2]),
      .wr_one    (flags_two_wr && wbyte[irq_flags_pkg::BIT_CAPCMP2]),
      .flag_ff   (flag_two)
   );

   // ---------------------------------------------------------------
   // Serial data register side effects
   // ---------------------------------------------------------------
   // One-cycle strobes tell the serial unit its buffer was touched
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_data_read_ff  <= 1'b0;
         tx_data_write_ff <= 1'b0;
         tx_data_ff       <= irq_flags_pkg::RST_DATA;
      end
      else
      begin
         rx_data_read_ff  <= rd_en && hit(idx, irq_flags_pkg::IDX_RX_DATA);
         tx_data_write_ff <= wr_en && hit(idx, irq_flags_pkg::IDX_TX_DATA);
         if (wr_en && hit(idx, irq_flags_pkg::IDX_TX_DATA))
            tx_data_ff <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // Request to the core
   // ---------------------------------------------------------------
   logic any_enabled;             // OR of masked flags

   assign any_enabled = |(flags_one & enables_one_ff)
                      | (flag_two & enables_two_ff[irq_flags_pkg::BIT_CAPCMP2]);

   // Registered so the output comes from a flop; one cycle of latency
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         periph_irq_ff <= 1'b0;
      else
         periph_irq_ff <= any_enabled
                        && core_ctrl_ff[irq_flags_pkg::BIT_PERIPH_EN]
                        && core_ctrl_ff[irq_flags_pkg::BIT_GLOBAL_EN];
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [7:0] rd_byte;           // Selected register
   logic       mapped;            // Address known

   always_comb
   begin
      rd_byte = 8'h00;
      mapped  = 1'b1;
      unique case (idx)
         irq_flags_pkg::IDX_FLAGS_ONE:   rd_byte = flags_one;
         irq_flags_pkg::IDX_FLAGS_TWO:   rd_byte = {7'h00, flag_two};
         irq_flags_pkg::IDX_ENABLES_ONE: rd_byte = enables_one_ff;
         irq_flags_pkg::IDX_ENABLES_TWO: rd_byte = enables_two_ff;
         irq_flags_pkg::IDX_CORE_CTRL:   rd_byte = core_ctrl_ff;
         irq_flags_pkg::IDX_RX_DATA:     rd_byte = 8'h00;
         irq_flags_pkg::IDX_TX_DATA:     rd_byte = tx_data_ff;
         default:                        mapped  = 1'b0;
      endcase
   end

   // Zero-wait slave; setup cycle registers the answer for the access phase
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Checks: request gating
   // ---------------------------------------------------------------
   // Either enable low holds the request down one edge later
   AST_GATE_GLOBAL: assert property (@(posedge clk) disable iff (!arst_n)
      !core_ctrl_ff[irq_flags_pkg::BIT_GLOBAL_EN] |=> !periph_irq_ff)
      else $error("request without global enable");
   AST_GATE_PERIPH: assert property (@(posedge clk) disable iff (!arst_n)
      !core_ctrl_ff[irq_flags_pkg::BIT_PERIPH_EN] |=> !periph_irq_ff)
      else $error("request without peripheral enable");
   // A masked-in flag with both enables set must get through
   AST_REQ_FOLLOWS: assert property (@(posedge clk) disable iff (!arst_n)
      any_enabled && core_ctrl_ff[irq_flags_pkg::BIT_GLOBAL_EN]
      && core_ctrl_ff[irq_flags_pkg::BIT_PERIPH_EN] |=> periph_irq_ff)
      else $error("enabled flag gave no request");
   // With every flag masked out the request stays low
   AST_MASKED: assert property (@(posedge clk) disable iff (!arst_n)
      (flags_one & enables_one_ff) == 8'h00
      && !(flag_two && enables_two_ff[irq_flags_pkg::BIT_CAPCMP2]) |=> !periph_irq_ff)
      else $error("request from a masked flag");

   // ---------------------------------------------------------------
   // Checks: flag setting
   // ---------------------------------------------------------------
   // Each event outside unit one PWM mode shows one edge later, whatever the enables hold
   AST_PAR_SET: assert property (@(posedge clk) disable iff (!arst_n)
      parallel_access |=> flags_one[irq_flags_pkg::BIT_PARALLEL])
      else $error("parallel port flag not set");
   AST_CONV_SET: assert property (@(posedge clk) disable iff (!arst_n)
      conversion_done |=> flags_one[irq_flags_pkg::BIT_CONVERTER])
      else $error("conversion flag not set");
   AST_SYNC_SET: assert property (@(posedge clk) disable iff (!arst_n)
      sync_serial_done |=> flags_one[irq_flags_pkg::BIT_SYNC])
      else $error("serial done flag not set");
   AST_CAP_SET: assert property (@(posedge clk) disable iff (!arst_n)
      capcmp_one_event && !capcmp_one_pwm_mode |=> flags_one[irq_flags_pkg::BIT_CAPCMP1])
      else $error("unit one flag not set");
   AST_PERIOD_SET: assert property (@(posedge clk) disable iff (!arst_n)
      period_match |=> flags_one[irq_flags_pkg::BIT_PERIOD])
      else $error("period match flag not set");
   AST_OVF_SET: assert property (@(posedge clk) disable iff (!arst_n)
      timer_one_overflow |=> flags_one[irq_flags_pkg::BIT_OVERFLOW])
      else $error("overflow flag not set");
   AST_TWO_SET: assert property (@(posedge clk) disable iff (!arst_n)
      capcmp_two_event |=> flag_two)
      else $error("unit two flag not set");
   // PWM mode must leave the unit one flag as it was
   AST_PWM_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
      capcmp_one_event && capcmp_one_pwm_mode && !flags_one[irq_flags_pkg::BIT_CAPCMP1]
      && !flags_one_wr |=> !flags_one[irq_flags_pkg::BIT_CAPCMP1])
      else $error("unit one flag set in PWM mode");

   // ---------------------------------------------------------------
   // Checks: clearing
   // ---------------------------------------------------------------
   // Nothing but a software write takes a sticky flag down
   AST_STICKY_ONE: assert property (@(posedge clk) disable iff (!arst_n)
      flags_one[irq_flags_pkg::BIT_SYNC] && !flags_one_wr
      |=> flags_one[irq_flags_pkg::BIT_SYNC])
      else $error("serial done flag dropped");
   // A zero write clears only when no event competes in that cycle
   AST_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
      flags_one_wr && !wbyte[irq_flags_pkg::BIT_OVERFLOW] && !timer_one_overflow
      |=> !flags_one[irq_flags_pkg::BIT_OVERFLOW])
      else $error("zero write did not clear");

   // ---------------------------------------------------------------
   // Checks: bus and serial strobes
   // ---------------------------------------------------------------
   AST_READY: assert property (@(posedge clk) disable iff (!arst_n)
      psel && !penable |=> pready)
      else $error("no ready in access phase");
   // Buffer bits are read live, never from a latch
   AST_LIVE_BITS: assert property (@(posedge clk) disable iff (!arst_n)
      psel && !penable && !pwrite && hit(idx, irq_flags_pkg::IDX_FLAGS_ONE)
      |=> prdata[irq_flags_pkg::BIT_RECEIVE] == $past(rx_buffer_full)
      && prdata[irq_flags_pkg::BIT_TRANSMIT] == $past(tx_buffer_empty))
      else $error("buffer bits not shown live");
   AST_RX_STROBE: assert property (@(posedge clk) disable iff (!arst_n)
      rd_en && hit(idx, irq_flags_pkg::IDX_RX_DATA) |=> rx_data_read_ff)
      else $error("receive read strobe missing");
   AST_TX_STROBE: assert property (@(posedge clk) disable iff (!arst_n)
      wr_en && hit(idx, irq_flags_pkg::IDX_TX_DATA) |=> tx_data_write_ff)
      else $error("transmit write strobe missing");
   // One cycle long, so the serial unit empties its buffer once per access
   AST_RX_ONCE: assert property (@(posedge clk) disable iff (!arst_n)
      rx_data_read_ff |=> !rx_data_read_ff)
      else $error("receive read strobe too long");

   // Main scenarios
   CV_IRQ: cover property (@(posedge clk) disable iff (!arst_n) $rose(periph_irq_ff));
   CV_SET_CLR: cover property (@(posedge clk) disable iff (!arst_n)
      timer_one_overflow && flags_one_wr && !wbyte[0]);
   CV_TX_WR: cover property (@(posedge clk) disable iff (!arst_n) tx_data_write_ff);
   CV_PWM_EVENT: cover property (@(posedge clk) disable iff (!arst_n)
      capcmp_one_event && capcmp_one_pwm_mode);
   CV_UNIT_TWO: cover property (@(posedge clk) disable iff (!arst_n)
      capcmp_two_event && enables_two_ff[irq_flags_pkg::BIT_CAPCMP2]);
endmodule
`default_nettype wire

// file: test/periph_model.sv
// Behavioural peripherals around the flag block: event pulses, buffers.
// Assumes the bench changes its requests just after rising edges.
`timescale 1ns/1ns
`default_nettype none
module periph_model
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [7:0] fire,             // One request bit per source
   input  wire logic       tx_sent,          // Byte has left the transmitter
   input  wire logic       rx_data_read_ff,
   input  wire logic       tx_data_write_ff,
   output logic            parallel_access,
   output logic            conversion_done,
   output logic            sync_serial_done,
   output logic            capcmp_one_event,
   output logic            period_match,
   output logic            timer_one_overflow,
   output logic            capcmp_two_event,
   output logic            rx_buffer_full,
   output logic            tx_buffer_empty
);
   // Events are one-cycle pulses one edge after the request
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         {parallel_access, conversion_done, sync_serial_done, capcmp_one_event,
          period_match, timer_one_overflow, capcmp_two_event} <= '0;
      else
         {parallel_access, conversion_done, sync_serial_done, capcmp_one_event,
          period_match, timer_one_overflow, capcmp_two_event} <=
            {fire[7], fire[6], fire[3], fire[2], fire[1], fire[0], fire[4]};
   end
   // Receive buffer fills on request, empties when software reads it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rx_buffer_full <= 1'b0;
      else if (fire[5])
         rx_buffer_full <= 1'b1;
      else if (rx_data_read_ff)
         rx_buffer_full <= 1'b0;
   end
   // Transmit buffer is empty after reset and full once written
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         tx_buffer_empty <= 1'b1;
      else if (tx_data_write_ff)
         tx_buffer_empty <= 1'b0;
      else if (tx_sent)
         tx_buffer_empty <= 1'b1;
   end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the peripheral flag block over APB.
// Assumes periph_model stands in for the peripherals.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pa, cd, rf, te, sd, pwm, c1, pm, t1, c2, rxr, txw, irq, tx_sent;
   logic [7:0]  txd, fire;
   int          failures, num_checks, cycles, rx_cnt, tx_cnt;

   // ---------------------------------------------
   // Clock, instances, strobe counters, timeout
   // ---------------------------------------------
   always #5 clk = ~clk;
   periph_irq dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .parallel_access(pa),
      .conversion_done(cd), .rx_buffer_full(rf), .tx_buffer_empty(te),
      .sync_serial_done(sd), .capcmp_one_pwm_mode(pwm), .capcmp_one_event(c1),
      .period_match(pm), .timer_one_overflow(t1), .capcmp_two_event(c2),
      .rx_data_read_ff(rxr), .tx_data_write_ff(txw), .tx_data_ff(txd),
      .periph_irq_ff(irq));
   periph_model per_u (.clk(clk), .arst_n(arst_n), .fire(fire), .tx_sent(tx_sent),
      .rx_data_read_ff(rxr), .tx_data_write_ff(txw), .parallel_access(pa),
      .conversion_done(cd), .sync_serial_done(sd), .capcmp_one_event(c1),
      .period_match(pm), .timer_one_overflow(t1), .capcmp_two_event(c2),
      .rx_buffer_full(rf), .tx_buffer_empty(te));
   always @(posedge clk)
   begin
      rx_cnt += (rxr === 1'b1);
      tx_cnt += (txw === 1'b1);
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         print_verdict();
      end
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; waits for pready, then leaves one idle edge
   task automatic apb(logic wr, logic [7:0] idx, logic [7:0] wd);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20)
         failures++;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Request one peripheral event and let it land
   task automatic pulse(int b);
      fire <= 8'h01 << b;
      @(posedge clk);
      fire <= 8'h00;
      repeat (4) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial
   begin
      clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; fire = '0; pwm = 0; tx_sent = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      // Reset values; transmit buffer starts empty
      apb(0, irq_flags_pkg::IDX_FLAGS_ONE, 0); check("flags1", rd, 32'h10);
      apb(0, irq_flags_pkg::IDX_FLAGS_TWO, 0); check("flags2", rd, 0);
      apb(0, irq_flags_pkg::IDX_ENABLES_ONE, 0); check("en1", rd, 0);
      apb(0, irq_flags_pkg::IDX_ENABLES_TWO, 0); check("en2", rd, 0);
      apb(0, irq_flags_pkg::IDX_CORE_CTRL, 0); check("ctrl", rd, 0);
      check("no error", err, 0);
      $display("test reset done");
      // Each source sets its flag with all enables off, and it sticks
      for (int b = 0; b < 8; b++)
      begin
         if (b == 5)
            continue;
         pulse(b);
         repeat (20) @(posedge clk);
         apb(0, (b == 4) ? 8'h0D : 8'h0C, 0);
         check("flag set", rd, (b == 4) ? 32'h01 : (32'h10 | (32'h1 << b)));
         apb(1, (b == 4) ? 8'h0D : 8'h0C, 0);
         apb(0, (b == 4) ? 8'h0D : 8'h0C, 0);
         check("flag clear", rd, (b == 4) ? 32'h00 : 32'h10);
      end
      pwm <= 1'b1;
      pulse(2);
      pwm <= 1'b0;
      apb(0, irq_flags_pkg::IDX_FLAGS_ONE, 0); check("pwm ignored", rd, 32'h10);
      $display("test events done");
      // Buffer flags follow the levels and ignore writes
      pulse(5);
      apb(1, irq_flags_pkg::IDX_FLAGS_ONE, 0);
      apb(0, irq_flags_pkg::IDX_FLAGS_ONE, 0); check("rx full", rd, 32'h30);
      apb(0, irq_flags_pkg::IDX_RX_DATA, 0);
      apb(0, irq_flags_pkg::IDX_FLAGS_ONE, 0); check("rx read", rd, 32'h10);
      apb(1, irq_flags_pkg::IDX_TX_DATA, 8'h5A);
      apb(0, irq_flags_pkg::IDX_FLAGS_ONE, 0); check("tx full", rd, 32'h00);
      check("tx byte", txd, 32'h5A);
      check("strobes", {rx_cnt[15:0], tx_cnt[15:0]}, 32'h00010001);
      tx_sent <= 1'b1;
      @(posedge clk);
      tx_sent <= 1'b0;
      $display("test buffers done");
      // An overflow in the very cycle of a zero write survives it
      fork
         apb(1, irq_flags_pkg::IDX_FLAGS_ONE, 0);
         begin
            fire <= 8'h01;
            @(posedge clk);
            fire <= 8'h00;
         end
      join
      apb(0, irq_flags_pkg::IDX_FLAGS_ONE, 0); check("set wins", rd, 32'h11);
      $display("test set wins done");
      // Gating by peripheral and global enables, overflow flag set and enabled first
      apb(1, irq_flags_pkg::IDX_ENABLES_ONE, 8'h01);
      pulse(0);
      for (int c = 0; c < 4; c++)
      begin
         apb(1, irq_flags_pkg::IDX_CORE_CTRL, 8'(c << 6) | 8'h3F);
         repeat (3) @(posedge clk);
         check("irq gate", irq, (c == 3));
      end
      apb(0, irq_flags_pkg::IDX_CORE_CTRL, 0); check("ctrl bits", rd, 32'hC0);
      // Enable bits 0 to 3 each pass only their own flag
      for (int k = 0; k < 4; k++)
      begin
         apb(1, irq_flags_pkg::IDX_FLAGS_ONE, 0);
         apb(1, irq_flags_pkg::IDX_ENABLES_ONE, 8'(1 << k));
         apb(1, irq_flags_pkg::IDX_FLAGS_ONE, 8'hCF & ~8'(1 << k));
         repeat (3) @(posedge clk);
         check("irq other", irq, 0);
         apb(1, irq_flags_pkg::IDX_FLAGS_ONE, 8'(1 << k));
         repeat (3) @(posedge clk);
         check("irq own", irq, 1);
      end
      apb(1, irq_flags_pkg::IDX_FLAGS_ONE, 0);
      apb(1, irq_flags_pkg::IDX_ENABLES_TWO, 8'hFF);
      apb(0, irq_flags_pkg::IDX_ENABLES_TWO, 0); check("en2 bit", rd, 32'h01);
      pulse(4);
      check("irq unit two", irq, 1);
      $display("test gating done");
      // Unmapped place answers with an error and zero data
      apb(1, 8'hFF, 8'hA5);
      apb(0, 8'hFF, 0); check("unmapped", {err, rd[30:0]}, 32'h80000000);
      $display("test unmapped done");
      print_verdict();
   end
endmodule
`default_nettype wire
